// ---- core/buck_switch_sequencer_power_good.v ----
// buck switch sequencer, reference clock selection, power-good debounce and apb registers
//
// Overview of operation
// - high-side switch turns on when minimum off-time ends after each falling edge of the active reference clock
// - high-side stays on past minimum on-time before current trip may end it
// - current trip turns high-side off, low-side on for at least minimum off-time
// - after a trip the low-side stays on until next reference falling edge
// - while enabled one switch is always on; never both off
// - each falling edge starts minimum off-time then minimum on-time, unconditionally
// - slope ramp discharge is active whenever the low-side switch is on
// - resistor select pin low picks internal resistor, high picks external pin
// - shutdown low drives neither switch; switch output is tristate
// - enabled only with lockout cleared and shutdown released
// - soft-start node pulled low during shutdown, released when shutdown ends
// - internal oscillator runs free at 500 kHz or 1 MHz
// - external sync from 100 kHz to 5 MHz replaces the internal oscillator
// - in-window counter counts reference cycles only while feedback stays in window
// - power-good asserts when in-window count reaches 64
// - leaving window during assert count resets it; flag stays low
// - window has hysteresis so entry and exit do not chatter
// - when good and out of window, flag drops after 64 reference cycles
// - re-entering window during deassert count resets it; flag stays high
// - power-good is open drain for cascading into another shutdown input
// - sync high or open selects 1 MHz, low selects 500 kHz; clocked sync is reference
// - open-drain output carries the inverted reference clock
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "buck_regs.vh"

module buck_switch_sequencer_power_good #(
  parameter integer MIN_ON_CYC   = ((`MIN_ON_NS * (`CLK_KHZ / 1000)) + 999) / 1000,
  parameter integer MIN_OFF_CYC  = ((`MIN_OFF_NS * (`CLK_KHZ / 1000)) + 999) / 1000,
  parameter integer PG_CYC       = `PG_COUNT,
  parameter integer SYNC_TIMEOUT = `CLK_KHZ / `SYNC_MIN_KHZ
) (
  input  wire        clk_in,
  input  wire        reset_n_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output reg  [31:0] prdata_out,
  output wire        pslverr_out,
  // control pins
  input  wire        shutdown_low_input_n_in,
  input  wire        supply_lockout_in,
  input  wire        sync_in,
  input  wire        set_resistor_select_in,
  input  wire        current_trip_in,
  input  wire        fb_window_enter_in,
  input  wire        fb_window_stay_in,
  // power stage
  output reg         hs_switch_on_out,
  output reg         ls_switch_on_out,
  output reg         switch_tristate_out,
  output wire        slope_ramp_discharge_out,
  output reg         set_resistor_external_out,
  output reg         softstart_pulldown_out,
  // open-drain outputs: level pin is always 0, enable pulls low
  output wire        output_ok_flag_out,
  output wire        output_ok_flag_oe_out,
  output wire        inverted_clock_out,
  output wire        inverted_clock_oe_out
);

  // codes are visible in the status register, so keep them stable
  localparam [2:0] ST_DIS  = 3'h0;
  localparam [2:0] ST_MOFF = 3'h1;
  localparam [2:0] ST_MON  = 3'h2;
  localparam [2:0] ST_HS   = 3'h3;
  localparam [2:0] ST_TRIP = 3'h4;
  localparam [2:0] ST_LS   = 3'h5;

  // integer forms first, then cut to the counter widths on purpose
  localparam integer ON_LOAD_I   = MIN_ON_CYC - 1;
  localparam integer OFF_LOAD_I  = MIN_OFF_CYC - 1;
  localparam integer HALF_FAST_I = (`CLK_KHZ / (2 * `OSC_FAST_KHZ)) - 1;
  localparam integer HALF_SLOW_I = (`CLK_KHZ / (2 * `OSC_SLOW_KHZ)) - 1;
  localparam integer SYNC_LOAD_I = SYNC_TIMEOUT;
  localparam integer PG_LAST_I   = PG_CYC - 1;

  localparam [7:0]  ON_LOAD    = ON_LOAD_I[7:0];
  localparam [7:0]  OFF_LOAD   = OFF_LOAD_I[7:0];
  localparam [8:0]  HALF_FAST  = HALF_FAST_I[8:0];
  localparam [8:0]  HALF_SLOW  = HALF_SLOW_I[8:0];
  localparam [11:0] SYNC_LOAD  = SYNC_LOAD_I[11:0];
  localparam [6:0]  PG_LAST    = PG_LAST_I[6:0];

  reg  [1:0]  ctrl_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  tm_ff;
  reg  [7:0]  nxt_tm;
  reg  [8:0]  osc_cnt_ff;
  reg         osc_ff;
  reg         sync_q_ff;
  reg         sync_seen_ff;
  reg         src_ext_ff;
  reg  [11:0] sync_act_ff;
  reg         ref_ff;
  reg         nxt_ref;
  reg         in_win_ff;
  reg         output_ok_flag_ff;
  reg  [6:0]  pg_cnt_ff;
  reg  [31:0] nxt_rdata;
  reg         addr_ok;

  wire enabled  = shutdown_low_input_n_in & ~supply_lockout_in & ctrl_ff[`CTRL_RUN_BIT];
  wire ext_sync = (sync_act_ff != 12'h000) & ~ctrl_ff[`CTRL_FORCE_INT];
  wire ref_fall = ref_ff & ~nxt_ref;
  wire apb_wr   = psel_in & penable_in & pwrite_in;
  wire apb_setup = psel_in & ~penable_in;
  wire sync_edge = sync_seen_ff & (sync_in != sync_q_ff);
  wire pg_done   = (pg_cnt_ff == PG_LAST);

  // countdown helpers shared by the three timed states
  function tm_expired;
    input [7:0] cnt;
    begin
      tm_expired = (cnt == 8'h00);
    end
  endfunction

  function [7:0] tm_step;
    input [7:0] cnt;
    begin
      tm_step = cnt - 8'h01;
    end
  endfunction

  // switch drive decode of a sequencer state
  function state_hs_on;
    input [2:0] st;
    begin
      state_hs_on = (st == ST_MON) | (st == ST_HS);
    end
  endfunction

  function state_ls_on;
    input [2:0] st;
    begin
      state_ls_on = (st == ST_MOFF) | (st == ST_TRIP) | (st == ST_LS);
    end
  endfunction

  // internal oscillator; a static sync level picks the rate
  // the rate pin is compared every cycle, so a new rate applies within the current half period
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_cnt_ff <= 9'h000;
      osc_ff     <= 1'b0;
    end else if (osc_cnt_ff >= (sync_in ? HALF_FAST : HALF_SLOW)) begin
      osc_cnt_ff <= 9'h000;
      osc_ff     <= ~osc_ff;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 9'h001;
    end
  end

  // sync is taken as external clock while it keeps toggling within one slowest period
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_q_ff    <= 1'b0;
      sync_seen_ff <= 1'b0;
      sync_act_ff  <= 12'h000;
    end else begin
      sync_q_ff    <= sync_in;
      // the first sample only primes the detector; a tied-high pin is no edge
      sync_seen_ff <= 1'b1;
      if (sync_edge) begin
        sync_act_ff <= SYNC_LOAD;
      end else if (sync_act_ff != 12'h000) begin
        sync_act_ff <= sync_act_ff - 12'h001;
      end
    end
  end

  // hand over between sources only where both show the same level, so a
  // change of source never makes a short reference cycle
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_ext_ff <= 1'b0;
    end else if ((src_ext_ff != ext_sync) && ((ext_sync ? sync_in : osc_ff) == nxt_ref)) begin
      src_ext_ff <= ext_sync;
    end
  end

  always @* begin
    nxt_ref = src_ext_ff ? sync_in : osc_ff;
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_ff <= 1'b0;
    end else begin
      // one flop of delay so the fall detect compares settled state
      ref_ff <= nxt_ref;
    end
  end

  // switch sequencer
  // a reference fall wins over whatever state the cycle has reached
  always @* begin
    nxt_state = state_ff;
    nxt_tm    = tm_ff;
    if (!enabled) begin
      nxt_state = ST_DIS;
    end else if (ref_fall) begin
      nxt_state = ST_MOFF;
      nxt_tm    = OFF_LOAD;
    end else begin
      case (state_ff)
        ST_DIS: begin
          // start with low-side on so conduction never breaks
          nxt_state = ST_LS;
        end
        ST_MOFF: begin
          if (tm_expired(tm_ff)) begin
            nxt_state = ST_MON;
            nxt_tm    = ON_LOAD;
          end else begin
            nxt_tm = tm_step(tm_ff);
          end
        end
        ST_MON: begin
          // trips are masked until the minimum on-time has run
          if (tm_expired(tm_ff)) begin
            nxt_state = current_trip_in ? ST_TRIP : ST_HS;
            nxt_tm    = OFF_LOAD;
          end else begin
            nxt_tm = tm_step(tm_ff);
          end
        end
        ST_HS: begin
          if (current_trip_in) begin
            nxt_state = ST_TRIP;
            nxt_tm    = OFF_LOAD;
          end
        end
        ST_TRIP: begin
          if (tm_expired(tm_ff)) begin
            nxt_state = ST_LS;
          end else begin
            nxt_tm = tm_step(tm_ff);
          end
        end
        ST_LS: begin
          nxt_state = ST_LS;
        end
        default: begin
          nxt_state = ST_DIS;
        end
      endcase
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff            <= ST_DIS;
      tm_ff               <= 8'h00;
      hs_switch_on_out    <= 1'b0;
      ls_switch_on_out    <= 1'b0;
      switch_tristate_out <= 1'b1;
    end else begin
      // pins decode the next state so they move together with the state
      state_ff            <= nxt_state;
      tm_ff               <= nxt_tm;
      hs_switch_on_out    <= state_hs_on(nxt_state);
      ls_switch_on_out    <= state_ls_on(nxt_state);
      switch_tristate_out <= (nxt_state == ST_DIS);
    end
  end

  assign slope_ramp_discharge_out = ls_switch_on_out;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      set_resistor_external_out <= 1'b0;
      softstart_pulldown_out    <= 1'b1;
    end else begin
      set_resistor_external_out <= set_resistor_select_in;
      // follows the shutdown pin alone; lockout does not hold the soft-start node
      softstart_pulldown_out    <= ~shutdown_low_input_n_in;
    end
  end

  // enter on the narrow comparator, leave only past the wide one
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_win_ff <= 1'b0;
    end else begin
      in_win_ff <= in_win_ff ? fb_window_stay_in : fb_window_enter_in;
    end
  end

  // power-good: 64-cycle debounce each way, counted on reference falls only,
  // so the debounce time scales with the switching rate, not the system clock
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      output_ok_flag_ff  <= 1'b0;
      pg_cnt_ff <= 7'h00;
    end else begin
      if (!enabled) begin
        output_ok_flag_ff  <= 1'b0;
        pg_cnt_ff <= 7'h00;
      end else if (in_win_ff == output_ok_flag_ff) begin
        pg_cnt_ff <= 7'h00;
      end else if (ref_fall) begin
        if (pg_done) begin
          output_ok_flag_ff  <= in_win_ff;
          pg_cnt_ff <= 7'h00;
        end else begin
          pg_cnt_ff <= pg_cnt_ff + 7'h01;
        end
      end
    end
  end

  // level pins stay low; the enables alone make the open-drain pulls
  assign output_ok_flag_out    = 1'b0;
  assign output_ok_flag_oe_out = ~output_ok_flag_ff;
  assign inverted_clock_out    = 1'b0;
  assign inverted_clock_oe_out = ref_ff;

  // apb slave: zero wait states, read data latched in the setup cycle
  // reads have no side effects, so latching them early is harmless
  always @* begin
    addr_ok   = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (paddr_in)
      `REG_CTRL: begin
        nxt_rdata[1:0] = ctrl_ff;
      end
      `REG_STATUS: begin
        nxt_rdata[`ST_ENABLED_BIT] = enabled;
        nxt_rdata[`ST_OUTPUT_OK_FLAG_BIT]   = output_ok_flag_ff;
        nxt_rdata[`ST_EXTSYNC_BIT] = ext_sync;
        nxt_rdata[`ST_INWIN_BIT]   = in_win_ff;
        nxt_rdata[`ST_REF_BIT]     = ref_ff;
        nxt_rdata[`ST_STATE_LSB +: 3] = state_ff;
      end
      `REG_PGCNT: begin
        nxt_rdata[6:0] = pg_cnt_ff;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ff    <= `CTRL_RESET;
      prdata_out <= 32'h0000_0000;
    end else begin
      if (apb_setup && !pwrite_in) begin
        prdata_out <= nxt_rdata;
      end
      // writes to read-only words are dropped without an error
      if (apb_wr && (paddr_in == `REG_CTRL)) begin
        ctrl_ff <= pwdata_in[1:0];
      end
    end
  end

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

endmodule // buck_switch_sequencer_power_good

// ---- shared/buck_regs.vh ----
// register map, field positions, reset values and timing constants of the buck switch sequencer
`ifndef BUCK_REGS_VH
`define BUCK_REGS_VH

// system clock rate and documented times
`define CLK_KHZ          200000
`define OSC_FAST_KHZ     1000
`define OSC_SLOW_KHZ     500
`define SYNC_MIN_KHZ     100
`define SYNC_MAX_KHZ     5000
`define MIN_ON_NS        20
`define MIN_OFF_NS       20
`define PG_COUNT         64

// apb register byte offsets
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_PGCNT        8'h08

// control register fields
`define CTRL_RUN_BIT     0
`define CTRL_FORCE_INT   1
`define CTRL_RESET       2'h1

// status register fields
`define ST_ENABLED_BIT   0
`define ST_OUTPUT_OK_FLAG_BIT     1
`define ST_EXTSYNC_BIT   2
`define ST_INWIN_BIT     3
`define ST_REF_BIT       4
`define ST_STATE_LSB     8

`endif

// ---- sim/buck_switch_sequencer_power_good_asserts.sv ----
// port-level assertion checker for the buck switch sequencer
`timescale 1ns/1ps
module buck_seq_checker (
  input logic clk_in,
  input logic reset_n_in,
  input logic shutdown_low_input_n_in,
  input logic set_resistor_select_in,
  input logic hs_switch_on_out,
  input logic ls_switch_on_out,
  input logic switch_tristate_out,
  input logic slope_ramp_discharge_out,
  input logic set_resistor_external_out,
  input logic softstart_pulldown_out,
  input logic output_ok_flag_oe_out,
  input logic inverted_clock_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // a disable may cut either hold short, so tristate also satisfies it
  sequence hs_hold_s; (hs_switch_on_out || switch_tristate_out)[*4]; endsequence
  sequence ls_hold_s; (ls_switch_on_out || switch_tristate_out)[*4]; endsequence
  conduction_kept_a: assert property (!switch_tristate_out |-> hs_switch_on_out || ls_switch_on_out)
    else $error("both switches off");
  min_on_a: assert property ($rose(hs_switch_on_out) |-> hs_hold_s)
    else $error("on time short");
  min_off_a: assert property ($fell(hs_switch_on_out) |-> ls_hold_s)
    else $error("off time short");
  cycle_start_a: assert property ($fell(inverted_clock_oe_out) && !switch_tristate_out |->
    ls_switch_on_out ##4 (hs_switch_on_out || switch_tristate_out)) else $error("cycle start wrong");
  sd_tristate_a: assert property (!shutdown_low_input_n_in |=> switch_tristate_out && !hs_switch_on_out)
    else $error("not tristate");
  softstart_a: assert property (1 |=> softstart_pulldown_out == !$past(shutdown_low_input_n_in))
    else $error("softstart pull wrong");
  ramp_reset_a: assert property (slope_ramp_discharge_out == ls_switch_on_out)
    else $error("ramp discharge wrong");
  set_resistor_select_copy_a: assert property (1 |=> set_resistor_external_out == $past(set_resistor_select_in))
    else $error("resistor select wrong");
  pg_clear_a: assert property (switch_tristate_out |-> output_ok_flag_oe_out)
    else $error("good while off");
endmodule // buck_seq_checker
bind buck_switch_sequencer_power_good buck_seq_checker u_buck_seq_checker (.clk_in, .reset_n_in,
  .shutdown_low_input_n_in, .set_resistor_select_in, .hs_switch_on_out, .ls_switch_on_out, .switch_tristate_out,
  .slope_ramp_discharge_out, .set_resistor_external_out, .softstart_pulldown_out, .output_ok_flag_oe_out,
  .inverted_clock_oe_out);

// ---- sim/power_stage_model.sv ----
// power stage, current comparator and feedback window comparators
`timescale 1ns/1ps
module power_stage_model (
  input  logic clk_in,
  input  logic hs_on_in,
  input  int   trip_delay_in,
  input  int   fb_mv_in,
  output logic current_trip_out,
  output logic window_enter_out,
  output logic window_stay_out
);
  int hs_cnt = 0;
  initial {current_trip_out, window_enter_out, window_stay_out} = 3'h0;
  always @(posedge clk_in) begin
    hs_cnt <= hs_on_in ? hs_cnt + 1 : 0;
    current_trip_out <= hs_on_in && hs_cnt >= trip_delay_in;
    window_enter_out <= fb_mv_in >= 900 && fb_mv_in <= 1100;
    // wider exit window gives 30 mV of hysteresis
    window_stay_out <= fb_mv_in >= 870 && fb_mv_in <= 1130;
  end
endmodule // power_stage_model

// ---- sim/tb_top.sv ----
// self-checking bench for the buck switch sequencer
`timescale 1ns/1ps
module tb_top;
  logic        clk_in, reset_n_in, psel, penable, pwrite, sd_n, lockout, sync, set_resistor_select, ext_on, err;
  logic        pready, pslverr, trip, w_in, w_stay, hs, ls, tri_st, ss, ok_oe, ck_oe, rx, od_ok, od_ck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_count, total_checks, trip_dly, fb_mv, n, sc, cyc;
  buck_switch_sequencer_power_good #(.PG_CYC(4), .SYNC_TIMEOUT(50)) u_buck_switch_sequencer_power_good (
    .clk_in, .reset_n_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .shutdown_low_input_n_in(sd_n), .supply_lockout_in(lockout), .sync_in(sync), .set_resistor_select_in(set_resistor_select),
    .current_trip_in(trip), .fb_window_enter_in(w_in), .fb_window_stay_in(w_stay), .hs_switch_on_out(hs),
    .ls_switch_on_out(ls), .switch_tristate_out(tri_st), .slope_ramp_discharge_out(),
    .set_resistor_external_out(rx), .softstart_pulldown_out(ss), .output_ok_flag_out(od_ok),
    .output_ok_flag_oe_out(ok_oe), .inverted_clock_out(od_ck), .inverted_clock_oe_out(ck_oe));
  power_stage_model u_power_stage_model (.clk_in, .hs_on_in(hs), .trip_delay_in(trip_dly), .fb_mv_in(fb_mv),
    .current_trip_out(trip), .window_enter_out(w_in), .window_stay_out(w_stay));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    sc <= (sc == 19) ? 0 : sc + 1;
    if (ext_on && sc == 19) sync <= ~sync;
  end
  task chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rise;
    while (hs !== 1'b0) @(posedge clk_in);
    while (hs !== 1'b1) @(posedge clk_in);
  endtask
  task period(output int p);
    int t;
    rise();
    t = cyc;
    rise();
    p = cyc - t;
  endtask
  // ref falls are seen on the inverted clock pin's enable
  task falls(input int k);
    repeat (k) begin
      while (ck_oe !== 1'b1) @(posedge clk_in);
      while (ck_oe !== 1'b0) @(posedge clk_in);
    end
    repeat (2) @(posedge clk_in);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    {reset_n_in, psel, penable, pwrite, lockout, set_resistor_select, ext_on, paddr, pwdata} = 0;
    {sd_n, sync, trip_dly, fb_mv, err_count, total_checks, sc, cyc} = {2'h3, 32'd1000, 160'h0};
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1, "ctrl reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk_in);
    chk(tri_st, 1'b1, "run off");
    apb(1'b1, 8'h00, 32'h1);
    set_resistor_select <= 1'b1;
    period(n);
    chk(n, 32'hc8, "1 MHz period");
    chk(rx, 1'b1, "resistor select");
    {sync, trip_dly} <= {1'b0, 32'd10};
    period(n);
    period(n);
    chk(n, 32'h190, "500 kHz period");
    {ext_on, trip_dly} <= {1'b1, 32'd0};
    period(n);
    period(n);
    chk(n, 32'h28, "sync period");
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h5, 32'h1, "forced internal");
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h5, 32'h5, "sync detected");
    falls(1);
    fb_mv <= 1000;
    falls(2);
    fb_mv <= 0;
    falls(1);
    fb_mv <= 1000;
    falls(3);
    chk(ok_oe, 1'b1, "good early");
    falls(1);
    chk(ok_oe, 1'b0, "good missing");
    fb_mv <= 1120;
    falls(5);
    chk(ok_oe, 1'b0, "hysteresis");
    fb_mv <= 1200;
    falls(2);
    fb_mv <= 1000;
    falls(1);
    fb_mv <= 1200;
    falls(3);
    chk(ok_oe, 1'b0, "dropped early");
    falls(1);
    chk(ok_oe, 1'b1, "not dropped");
    fb_mv <= 1000;
    falls(5);
    sd_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk({tri_st, hs, ls, ss, ok_oe}, 5'h13, "shutdown");
    {sd_n, lockout} <= 2'h3;
    repeat (5) @(posedge clk_in);
    chk({tri_st, ss}, 2'h2, "lockout");
    lockout <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(tri_st, 1'b0, "enable");
    chk({od_ok, od_ck}, 2'h0, "open drain level");
    complete_run();
  end
endmodule // tb_top
